// >>> sff_fast_read.sv
// Fast read command decoder and read datapath of a serial flash slave
`timescale 1ns/1ps
`default_nettype none
`include "sff_map.svh"
module sff_fast_read (
	input  wire logic        i_clock,
	input  wire logic        i_srst,
	input  wire logic        i_chip_select_n,
	input  wire logic        i_serial_clock,
	input  wire logic [3:0]  i_data_line,
	output logic      [3:0]  o_data_line_out,
	output logic      [3:0]  o_data_line_oe,
	input  wire logic        i_quad_mode_enable_bit,
	input  wire logic        i_address_size_flag,
	input  wire logic        i_qpi_mode,
	input  wire logic [7:0]  i_ext_address,
	output logic      [31:0] o_mem_addr,
	input  wire logic [7:0]  i_mem_data,
	output logic             o_wrap_disable_bit,
	output logic      [1:0]  o_wrap_length_field
);
	logic [5:0]            pins;
	logic                  cs_n, sclk, sclk_prev_q, rise, fall;
	logic [3:0]            din, out_q, oe_q;
	sff_pkg::sff_state_e   state_q;
	logic [5:0]            cnt_q, cnt_plus, abits_q, dummy_q, dec_dummy;
	logic [6:0]            op_sh_q;
	logic [7:0]            opcode, out_sh_q;
	logic [31:0]           sh_q, sh_next, rd_addr_q;
	sff_pkg::sff_lanes_t   alanes_q, dlanes_q, dec_alanes, dec_dlanes;
	logic                  has_mode_q, set_wrap_q, wrap_app_q, addr_done;
	logic                  wrap_dis_q;
	logic [1:0]            wrap_len_q;
	logic [2:0]            bitpos_q;
	logic                  dec_ok, dec_fixed4, dec_quad, dec_mode;
	logic                  dec_setwrap, dec_wrapcmd;
	function automatic logic [31:0] shift_in(input logic [31:0] v,
		input sff_pkg::sff_lanes_t n, input logic [3:0] d);
		case (n)
			`SFF_LANES_2: shift_in = {v[29:0], d[1:0]};
			`SFF_LANES_4: shift_in = {v[27:0], d};
			default:      shift_in = {v[30:0], d[0]};
		endcase
	endfunction
	// Top bits of a byte onto the lanes, lowest lane gets lowest bit
	function automatic logic [3:0] lane_bits(input logic [7:0] b,
		input sff_pkg::sff_lanes_t n);
		case (n)
			`SFF_LANES_2: lane_bits = {2'h0, b[7:6]};
			`SFF_LANES_4: lane_bits = b[7:4];
			default:      lane_bits = {2'h0, b[7], 1'b0};
		endcase
	endfunction
	function automatic logic [3:0] lane_mask(input sff_pkg::sff_lanes_t n);
		case (n)
			`SFF_LANES_2: lane_mask = 4'h3;
			`SFF_LANES_4: lane_mask = 4'hf;
			default:      lane_mask = 4'h2;
		endcase
	endfunction
	function automatic logic [31:0] next_addr(input logic [31:0] a,
		input logic wrap, input logic [1:0] len);
		logic [7:0] m;
		logic [7:0] inc;
		m = (`SFF_WRAP_MIN_BYTES << len) - 8'h01;
		inc = a[7:0] + 8'h01;
		if (wrap) begin
			next_addr = {a[31:8], (a[7:0] & ~m) | (inc & m)};
		end else begin
			next_addr = a + 32'h0000_0001;
		end
	endfunction
	sff_sync #(.WIDTH(6)) u_sync (
		.i_clock(i_clock), .i_srst(i_srst),
		.i_pin({i_chip_select_n, i_serial_clock, i_data_line}),
		.i_reset_value(6'h20), .o_level(pins));
	assign cs_n = pins[5];
	assign sclk = pins[4];
	assign din  = pins[3:0];
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk;
		end
	end
	assign rise = !cs_n && sclk && !sclk_prev_q;
	assign fall = !cs_n && !sclk && sclk_prev_q;
	assign opcode = {op_sh_q, din[0]};
	assign sh_next = shift_in(sh_q, alanes_q, din);
	assign cnt_plus = cnt_q + {3'h0, alanes_q};
	assign addr_done = rise && state_q == sff_pkg::ST_ADDR &&
		cnt_plus == abits_q && !set_wrap_q;
	always_comb begin
		dec_ok = 1'b1;
		dec_fixed4 = 1'b0;
		dec_quad = 1'b0;
		dec_mode = 1'b0;
		dec_setwrap = 1'b0;
		dec_wrapcmd = 1'b0;
		dec_dummy = `SFF_DUMMY_OUT;
		dec_alanes = `SFF_LANES_1;
		dec_dlanes = `SFF_LANES_1;
		case (opcode)
			`SFF_OP_FAST_READ: ;
			`SFF_OP_FAST_READ_4B: dec_fixed4 = 1'b1;
			`SFF_OP_DUAL_OUT: dec_dlanes = `SFF_LANES_2;
			`SFF_OP_DUAL_OUT_4B: begin
				dec_dlanes = `SFF_LANES_2;
				dec_fixed4 = 1'b1;
			end
			`SFF_OP_QUAD_OUT: begin
				dec_dlanes = `SFF_LANES_4;
				dec_quad = 1'b1;
			end
			`SFF_OP_QUAD_OUT_4B: begin
				dec_dlanes = `SFF_LANES_4;
				dec_quad = 1'b1;
				dec_fixed4 = 1'b1;
			end
			`SFF_OP_DUAL_IO, `SFF_OP_DUAL_IO_4B: begin
				dec_alanes = `SFF_LANES_2;
				dec_dlanes = `SFF_LANES_2;
				dec_mode = 1'b1;
				dec_dummy = `SFF_DUMMY_DUAL_IO;
				dec_fixed4 = opcode == `SFF_OP_DUAL_IO_4B;
			end
			`SFF_OP_QUAD_IO, `SFF_OP_QUAD_IO_4B: begin
				dec_alanes = `SFF_LANES_4;
				dec_dlanes = `SFF_LANES_4;
				dec_mode = 1'b1;
				dec_quad = 1'b1;
				dec_wrapcmd = 1'b1;
				dec_dummy = `SFF_DUMMY_QUAD_IO;
				dec_fixed4 = opcode == `SFF_OP_QUAD_IO_4B;
			end
			`SFF_OP_SET_WRAP: begin
				dec_alanes = `SFF_LANES_4;
				dec_setwrap = 1'b1;
			end
			default: dec_ok = 1'b0;
		endcase
		if ((dec_fixed4 && i_qpi_mode) ||
			(dec_quad && !i_quad_mode_enable_bit)) begin
			dec_ok = 1'b0;
		end
	end
	// Command phase sequencing on serial clock rising edges
	always_ff @(posedge i_clock) begin
		if (i_srst || cs_n) begin
			state_q <= sff_pkg::ST_OPCODE;
			cnt_q <= 6'h00;
			op_sh_q <= 7'h00;
			sh_q <= 32'h0000_0000;
			abits_q <= `SFF_ADDR_BITS_3B;
			alanes_q <= `SFF_LANES_1;
			dlanes_q <= `SFF_LANES_1;
			dummy_q <= 6'h00;
			has_mode_q <= 1'b0;
			set_wrap_q <= 1'b0;
			wrap_app_q <= 1'b0;
		end else if (rise) begin
			case (state_q)
				sff_pkg::ST_OPCODE: begin
					op_sh_q <= opcode[6:0];
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == `SFF_OPCODE_LAST) begin
						cnt_q <= 6'h00;
						state_q <= dec_ok ? sff_pkg::ST_ADDR :
							sff_pkg::ST_IGNORE;
						abits_q <= (dec_fixed4 || i_address_size_flag) ?
							`SFF_ADDR_BITS_4B : `SFF_ADDR_BITS_3B;
						alanes_q <= dec_alanes;
						dlanes_q <= dec_dlanes;
						dummy_q <= dec_dummy;
						has_mode_q <= dec_mode;
						set_wrap_q <= dec_setwrap;
						wrap_app_q <= dec_wrapcmd && !wrap_dis_q;
					end
				end
				sff_pkg::ST_ADDR: begin
					sh_q <= sh_next;
					cnt_q <= cnt_plus;
					if (cnt_plus == abits_q) begin
						cnt_q <= 6'h00;
						if (set_wrap_q) begin
							state_q <= sff_pkg::ST_WRAP;
						end else if (has_mode_q) begin
							state_q <= sff_pkg::ST_MODE;
						end else begin
							state_q <= sff_pkg::ST_DUMMY;
						end
					end
				end
				sff_pkg::ST_MODE, sff_pkg::ST_WRAP: begin
					// Mode byte is taken but not acted on
					sh_q <= sh_next;
					cnt_q <= cnt_plus;
					if (cnt_plus == `SFF_MODE_BITS) begin
						cnt_q <= 6'h00;
						if (state_q == sff_pkg::ST_WRAP) begin
							state_q <= sff_pkg::ST_IGNORE;
						end else if (dummy_q == 6'h00) begin
							state_q <= sff_pkg::ST_DATA;
						end else begin
							state_q <= sff_pkg::ST_DUMMY;
						end
					end
				end
				sff_pkg::ST_DUMMY: begin
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q + 6'h01 == dummy_q) begin
						state_q <= sff_pkg::ST_DATA;
					end
				end
				default: ;
			endcase
		end
	end
	// Wrap setting survives chip select, changed only by the wrap command
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			wrap_dis_q <= `SFF_WRAP_DIS_RESET;
			wrap_len_q <= `SFF_WRAP_LEN_RESET;
		end else if (rise && state_q == sff_pkg::ST_WRAP &&
			cnt_plus == `SFF_WRAP_BITS) begin
			wrap_dis_q <= sh_next[`SFF_WRAP_DIS_POS];
			wrap_len_q <= sh_next[`SFF_WRAP_LEN_HI:`SFF_WRAP_LEN_LO];
		end
	end
	// Read address: loaded at address end, stepped per output byte
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			rd_addr_q <= 32'h0000_0000;
		end else if (addr_done) begin
			if (abits_q == `SFF_ADDR_BITS_3B) begin
				rd_addr_q <= {i_ext_address, sh_next[23:0]};
			end else begin
				rd_addr_q <= sh_next;
			end
		end else if (fall && state_q == sff_pkg::ST_DATA &&
			bitpos_q == 3'h0) begin
			rd_addr_q <= next_addr(rd_addr_q, wrap_app_q, wrap_len_q);
		end
	end
	// Data out on falling edges; drivers off the clock after the synchronised chip select goes high
	always_ff @(posedge i_clock) begin
		if (i_srst || cs_n) begin
			out_sh_q <= 8'h00;
			bitpos_q <= 3'h0;
			out_q <= 4'h0;
			oe_q <= 4'h0;
		end else if (fall && state_q == sff_pkg::ST_DATA) begin
			oe_q <= lane_mask(dlanes_q);
			bitpos_q <= bitpos_q + dlanes_q;
			if (bitpos_q == 3'h0) begin
				out_q <= lane_bits(i_mem_data, dlanes_q);
				out_sh_q <= i_mem_data << dlanes_q;
			end else begin
				out_q <= lane_bits(out_sh_q, dlanes_q);
				out_sh_q <= out_sh_q << dlanes_q;
			end
		end
	end
	assign o_data_line_out = out_q;
	assign o_data_line_oe = oe_q;
	assign o_mem_addr = rd_addr_q;
	assign o_wrap_disable_bit = wrap_dis_q;
	assign o_wrap_length_field = wrap_len_q;
endmodule
`default_nettype wire

// >>> sff_fast_read_sva.sv
// Port-level assertions for the fast read block
`timescale 1ns/1ps
`default_nettype none
module sff_fast_read_chk (
	input wire logic       i_clock,
	input wire logic       i_srst,
	input wire logic       i_chip_select_n,
	input wire logic       i_serial_clock,
	input wire logic [3:0] i_data_line,
	input wire logic [3:0] o_data_line_out,
	input wire logic [3:0] o_data_line_oe,
	input wire logic       i_quad_mode_enable_bit,
	input wire logic       i_address_size_flag,
	input wire logic       i_qpi_mode,
	input wire logic       o_wrap_disable_bit,
	input wire logic [1:0] o_wrap_length_field
);
	logic       sclk_q;
	logic [9:0] rises_q;
	logic [7:0] op_q;
	wire        rise = i_serial_clock && !sclk_q && !i_chip_select_n;
	wire  [9:0] ab = (i_address_size_flag || op_q[2]) ? 10'd32 : 10'd24;

	always_ff @(posedge i_clock)
		sclk_q <= i_serial_clock;
	// Counted at the pins, so it runs ahead of the design's synchroniser
	always_ff @(posedge i_clock)
		if (i_srst || i_chip_select_n)
			rises_q <= 10'h0;
		else if (rise)
			rises_q <= rises_q + 10'h1;
	always_ff @(posedge i_clock)
		if (rise && rises_q < 10'h8)
			op_q <= {op_q[6:0], i_data_line[0]};

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);

	a_cs_oe_off: assert property (
		i_chip_select_n [*8] |-> o_data_line_oe == 4'h0)
		else $error("lines driven with chip select high");
	a_out_start_lat: assert property (
		$rose(o_data_line_oe[1]) && op_q[7:4] inside {4'h0, 4'h3}
		|-> rises_q == ab + 10'd16)
		else $error("output read data began at wrong clock");
	a_quad_out_lat: assert property (
		$rose(o_data_line_oe[3]) && op_q[7:4] == 4'h6
		|-> ##1 $past(rises_q) == ab + 10'd16)
		else $error("quad output data began at wrong clock");
	a_dual_io_lat: assert property (
		$rose(o_data_line_oe[0]) && op_q[7:4] == 4'hb
		|-> rises_q == (ab >> 1) + 10'd12)
		else $error("dual io data began at wrong clock");
	a_quad_io_lat: assert property (
		$rose(o_data_line_oe[2]) && op_q[7:4] == 4'he
		|-> rises_q == (ab >> 2) + 10'd14)
		else $error("quad io data began at wrong clock");
	a_fixed_four_refuse: assert property (
		i_qpi_mode && op_q[2] && rises_q >= 10'd8 |-> o_data_line_oe == 4'h0)
		else $error("fixed four byte read served outside standard mode");
	a_quad_gate: assert property (
		o_data_line_oe[3] |-> i_quad_mode_enable_bit)
		else $error("quad lines driven with quad enable low");
	a_out_hold_high: assert property (
		i_serial_clock && $past(i_serial_clock, 2) |-> $stable(o_data_line_out))
		else $error("output changed while serial clock high");
	a_wrap_change_cmd: assert property (
		$changed({o_wrap_disable_bit, o_wrap_length_field})
		|-> op_q == 8'h77 && !$past(i_chip_select_n, 3))
		else $error("wrap bits changed outside a wrap command");

	c_quad: cover property (o_data_line_oe == 4'hf);
	c_dual: cover property (o_data_line_oe == 4'h3);
	c_wrap_on: cover property ($fell(o_wrap_disable_bit));
endmodule
bind sff_fast_read sff_fast_read_chk chk (.*);
`default_nettype wire

// >>> sff_host.sv
// Behavioural SPI host driving the fast read block
`timescale 1ns/1ps
`default_nettype none
module sff_host (
	input  wire logic       i_clock,
	input  wire logic [3:0] i_line,
	output logic            o_cs_n,
	output logic            o_sclk,
	output logic      [3:0] o_hd,
	output logic      [3:0] o_hoe,
	output logic      [7:0] o_byte,
	output logic            o_byte_vld
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_hd = 4'h0;
		o_hoe = 4'h0;
		o_byte = 8'h00;
		o_byte_vld = 1'b0;
	end

	// Mode 0: data set with the fall, sampled at the rise
	task automatic tick(input logic [3:0] v, output logic [3:0] s);
		o_sclk = 1'b0;
		o_hd = v;
		repeat (5) @(negedge i_clock);
		o_sclk = 1'b1;
		s = i_line;
		repeat (5) @(negedge i_clock);
	endtask

	task automatic send(input logic [31:0] v, input int nb, input int n);
		logic [3:0] s;
		o_hoe = 4'((1 << n) - 1);
		for (int i = nb - n; i >= 0; i -= n)
			tick(4'(v >> i), s);
	endtask

	task automatic recv(input int nby, input int n);
		logic [3:0] s;
		logic [7:0] b;
		b = 8'h00;
		for (int k = 0; k < nby; k++) begin
			for (int i = 0; i < 8; i += n) begin
				tick(4'h0, s);
				// Lanes the device leaves floating must not leak in
				b = 8'(b << n) | 8'((n == 1) ? {3'h0, s[1]} :
					(n == 2) ? {2'h0, s[1:0]} : s);
			end
			o_byte = b;
			o_byte_vld = 1'b1;
			@(negedge i_clock);
			o_byte_vld = 1'b0;
		end
	endtask

	task automatic xfer(input logic [7:0] op, input logic [31:0] a,
		input int ab, input int an, input logic [7:0] m, input bit hm,
		input int dc, input int dn, input int nby);
		logic [3:0] s;
		o_cs_n = 1'b0;
		send(32'(op), 8, 1);
		send(a, ab, an);
		if (hm)
			send(32'(m), 8, an);
		// Freed before any data fall so the device never fights us
		o_hoe = 4'h0;
		repeat (dc) tick(4'h0, s);
		recv(nby, dn);
		o_sclk = 1'b0;
		repeat (2) @(negedge i_clock);
		o_cs_n = 1'b1;
		repeat (10) @(negedge i_clock);
	endtask
endmodule
`default_nettype wire

// >>> sff_map.svh
// Opcodes, field positions, reset values and phase counts of the read block
`ifndef SFF_MAP_SVH
`define SFF_MAP_SVH

`define SFF_OP_FAST_READ      8'h0b
`define SFF_OP_FAST_READ_4B   8'h0c
`define SFF_OP_DUAL_OUT       8'h3b
`define SFF_OP_DUAL_OUT_4B    8'h3c
`define SFF_OP_QUAD_OUT       8'h6b
`define SFF_OP_QUAD_OUT_4B    8'h6c
`define SFF_OP_DUAL_IO        8'hbb
`define SFF_OP_DUAL_IO_4B     8'hbc
`define SFF_OP_QUAD_IO        8'heb
`define SFF_OP_QUAD_IO_4B     8'hec
`define SFF_OP_SET_WRAP       8'h77

`define SFF_ADDR_BITS_3B      6'd24
`define SFF_ADDR_BITS_4B      6'd32
`define SFF_MODE_BITS         6'd8
`define SFF_WRAP_BITS         6'd8
`define SFF_DUMMY_OUT         6'd8
`define SFF_DUMMY_DUAL_IO     6'd0
`define SFF_DUMMY_QUAD_IO     6'd4
`define SFF_OPCODE_LAST       6'd7

`define SFF_WRAP_DIS_POS      4
`define SFF_WRAP_LEN_HI       6
`define SFF_WRAP_LEN_LO       5
`define SFF_WRAP_DIS_RESET    1'b1
`define SFF_WRAP_LEN_RESET    2'h0
`define SFF_WRAP_MIN_BYTES    8'h08

`define SFF_LANES_1           3'd1
`define SFF_LANES_2           3'd2
`define SFF_LANES_4           3'd4

`endif

// >>> sff_pkg.sv
// Types shared by the fast read block
`default_nettype none
package sff_pkg;
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_ADDR   = 3'b001,
		ST_MODE   = 3'b010,
		ST_DUMMY  = 3'b011,
		ST_DATA   = 3'b100,
		ST_WRAP   = 3'b101,
		ST_IGNORE = 3'b110
	} sff_state_e;

	typedef logic [2:0] sff_lanes_t;
endpackage
`default_nettype wire

// >>> sff_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sff_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clock,
	input  wire logic             i_srst,
	input  wire logic [WIDTH-1:0] i_pin,
	input  wire logic [WIDTH-1:0] i_reset_value,
	output logic      [WIDTH-1:0] o_level
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] level_q;

	always_ff @(posedge i_clock) begin
		s1_q <= i_pin;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	// Only bits where stages two and three agree are taken
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			level_q <= i_reset_value;
		end else begin
			level_q <= (level_q & ~(s2_q ^ s3_q)) ^
				(level_q & ~(s2_q ^ s3_q)) ^
				((s2_q & s3_q) | (level_q & (s2_q ^ s3_q)));
		end
	end

	assign o_level = level_q;
endmodule
`default_nettype wire

// >>> tb_sff_fast_read.sv
// Self-checking bench for the fast read block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_sff_fast_read;
	logic        i_clock = 1'b0;
	logic        i_srst = 1'b1;
	logic        qe = 1'b1;
	logic        flag = 1'b0;
	logic        qpi = 1'b0;
	logic [7:0]  ext = 8'h00;
	logic [3:0]  flt = 4'h5;
	logic        wdis = 1'b1;
	logic [1:0]  wlen = 2'h0;
	logic        drove = 1'b0;
	logic [7:0]  ex;
	int          fails = 0;
	int          tests_run = 0;
	int          cyc = 0;
	logic [7:0]  q[$];
	wire  [3:0]  out, oe, hd, hoe;
	wire         cs_n, sclk, vld, wd;
	wire  [1:0]  wl;
	wire  [7:0]  hb;
	wire  [31:0] ma;
	// Undriven lines toggle so a stale level never passes as data
	wire  [3:0]  line = (oe & out) | (~oe & hoe & hd) | (~oe & ~hoe & flt);
	wire  [7:0]  md = ma[7:0] ^ ma[31:24] ^ 8'ha5;
	localparam logic [7:0] ops [10] = '{8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b,
		8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec};

	sff_host host (.i_clock(i_clock), .i_line(line), .o_cs_n(cs_n),
		.o_sclk(sclk), .o_hd(hd), .o_hoe(hoe), .o_byte(hb), .o_byte_vld(vld));
	sff_fast_read dut (.i_clock(i_clock), .i_srst(i_srst),
		.i_chip_select_n(cs_n), .i_serial_clock(sclk), .i_data_line(line),
		.o_data_line_out(out), .o_data_line_oe(oe),
		.i_quad_mode_enable_bit(qe), .i_address_size_flag(flag),
		.i_qpi_mode(qpi), .i_ext_address(ext), .o_mem_addr(ma),
		.i_mem_data(md), .o_wrap_disable_bit(wd), .o_wrap_length_field(wl));

	always #5 i_clock = ~i_clock;
	always @(negedge i_clock) flt <= ~flt;
	always @(posedge i_clock) if (oe != 4'h0) drove <= 1'b1;

	task automatic results;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge i_clock) begin
		cyc++;
		if (vld && q.size() > 0) begin
			ex = q.pop_front();
			`CHK(hb, ex)
		end
		if (cyc == 100000) begin
			fails++;
			results();
		end
	end

	task automatic rd(input logic [7:0] op, input int nb);
		logic [31:0] a, e, x;
		logic [7:0] msk;
		int ab;
		int dn;
		bit bad;
		a = $urandom;
		ab = (flag || op[2]) ? 32 : 24;
		e = (ab == 32) ? a : {ext, a[23:0]};
		dn = (op[7:4] == 4'h0) ? 1 : (op[7:4] inside {4'h3, 4'hb}) ? 2 : 4;
		bad = (op[2] && qpi) || (op[7:4] inside {4'h6, 4'he} && !qe);
		msk = (op[7:4] == 4'he && !wdis) ? 8'((8 << wlen) - 1) : 8'h00;
		for (int k = 0; k < nb && !bad; k++) begin
			x = (msk != 8'h00) ? {e[31:8], (e[7:0] & ~msk) |
				(8'(e[7:0] + k) & msk)} : e + k;
			q.push_back(x[7:0] ^ x[31:24] ^ 8'ha5);
		end
		drove = 1'b0;
		host.xfer(op, a, ab, op[7] ? (op[6] ? 4 : 2) : 1, 8'hf0, op[7],
			op[7] ? (op[6] ? 4 : 0) : 8, dn, nb);
		if (bad)
			`CHK(drove, 1'b0)
		`CHK(q.size(), 0)
	endtask

	task automatic set_wrap(input logic dis, input logic [1:0] len);
		logic [7:0] w;
		w = {1'($urandom), len, dis, 4'($urandom)};
		host.xfer(8'h77, 32'h0, flag ? 32 : 24, 4, w, 1'b1, 0, 4, 0);
		wdis = dis;
		wlen = len;
		`CHK(wd, dis)
		`CHK(wl, len)
	endtask

	initial begin
		void'($urandom(73327));
		repeat (12) @(negedge i_clock);
		i_srst = 1'b0;
		repeat (4) @(negedge i_clock);
		`CHK(wd, 1'b1)
		for (int m = 0; m < 2; m++) begin
			flag = 1'(m);
			ext = 8'($urandom);
			foreach (ops[i])
				rd(ops[i], 3);
		end
		qpi = 1'b1;
		foreach (ops[i])
			rd(ops[i], 2);
		qpi = 1'b0;
		qe = 1'b0;
		foreach (ops[i])
			rd(ops[i], 2);
		qe = 1'b1;
		for (int c = 0; c < 4; c++) begin
			set_wrap(1'b0, 2'(c));
			rd(8'heb, (8 << c) + 3);
			rd(8'hec, 10);
			rd(8'h6b, 10);
		end
		set_wrap(1'b1, 2'h0);
		rd(8'heb, 12);
		results();
	end
endmodule
`default_nettype wire
